/* pkg/i2cm_cfg.svh */
/*
  Register offsets, field positions, mode codes and fixed values of the
  two-wire port. Assumes inclusion by the design file that uses them.
*/
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
`define I2CM_OFF_CTRL1 8'h00
`define I2CM_OFF_CTRL2 8'h04
`define I2CM_OFF_STAT 8'h08
`define I2CM_OFF_BUF 8'h0C
`define I2CM_OFF_ADDR 8'h10
`define I2CM_OFF_EVT 8'h14
`define I2CM_C1_WRITE_COLLISION_FLAG 7
`define I2CM_C1_EN 5
`define I2CM_C1_CRB 4
`define I2CM_C2_GCE 7
`define I2CM_C2_ACKDT 5
`define I2CM_C2_ACKEN 4
`define I2CM_C2_RCEN 3
`define I2CM_C2_PEN 2
`define I2CM_C2_RSEN 1
`define I2CM_C2_SEN 0
`define I2CM_EVT_IRQ 0
`define I2CM_MODE_S7 4'h6
`define I2CM_MODE_S10 4'h7
`define I2CM_MODE_MASTER 4'h8
`define I2CM_CRB_RST 1'b1
`define I2CM_LINES_IDLE 6'h3F
`define I2CM_PHASE_START 2'h0
`define I2CM_GC_ADDR 8'h00
`define I2CM_TEN_PREFIX 5'h1E
`define I2CM_TX_BITS 4'h9
`define I2CM_RX_BITS 4'h8
`define I2CM_ACK_BITS 4'h1
`define I2CM_LAST_BIT 4'h1
`define I2CM_BIT8 4'h7
`define I2CM_ACK_SLOT 4'h8
`define I2CM_BIT9 4'h9
`define I2CM_RESP_OKAY 2'h0
`define I2CM_RESP_SLVERR 2'h2
`endif

/* pkg/i2cm_pkg.sv */
/*
  Types of the two-wire port: state encodings and the packed state record.
  Assumes the numeric constants come from i2cm_cfg.svh.
*/
package i2cm_pkg;
  typedef enum logic [3:0] {
    M_IDLE = 4'h0, M_ST1 = 4'h1, M_ST2 = 4'h3, M_LOW = 4'h2, M_HIGH = 4'h6,
    M_SP1 = 4'h7, M_SP2 = 4'h5, M_SP3 = 4'h4, M_RS1 = 4'hC, M_RS2 = 4'hD,
    M_RS3 = 4'hF
  } i2cm_mst_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_ADDR = 2'h1, S_DATA = 2'h3} i2cm_slv_t;
  typedef enum logic [1:0] {K_TX = 2'h0, K_RX = 2'h1, K_ACK = 2'h3} i2cm_kind_t;
  typedef struct packed {
    logic en;
    logic crb;
    logic write_collision_flag;
    logic [3:0] mode;
    logic gce;
    logic ack_received_status;
    logic ackdt;
    logic acken;
    logic rcen;
    logic stop_request_bit;
    logic rsen;
    logic start_request_bit;
    logic start_seen;
    logic stop_seen;
    logic ua;
    logic bf;
    logic irq;
    logic [7:0] xbuf;
    logic [7:0] addr;
    logic [7:0] rate_counter;
    logic brg_run;
    logic [1:0] phase;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    i2cm_mst_t mst;
    i2cm_kind_t kind;
    logic [3:0] mbits;
    logic [7:0] mshift;
    logic m_scl_low;
    logic m_sda_low;
    i2cm_slv_t slv;
    logic [3:0] sbits;
    logic [7:0] sshift;
    logic s_match;
    logic s_gc;
    logic s_ack;
    logic s_second;
    logic s_hold;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } i2cm_state_t;
endpackage : i2cm_pkg

/* rtl/i2cm_top.sv */
/*
  Two-wire serial port: target-side address match with general call and
  clock hold, controller sequencer, rate counter with clock arbitration,
  and an AXI4-Lite register slave.
  Assumes scl/sda are open-drain wires resolved outside from the enables,
  and a 125 MHz clock standing in for the oscillator.
*/
// Functional notes
// - hold clock only after line already low
// - release clock on release bit plus bus
// - general call is zero byte, needs enable
// - shift eight bits, compare own and general
// - general call fills buffer, flags, interrupt
// - ten-bit match sets update flag
// - ten-bit general call skips update flag
// - controller mode drives clock and data
// - clear start/stop flags on reset, disable
// - busy buffer write discarded, collision flag
// - interrupt on every completed controller operation, none on start abort
// - address byte plus direction bit
// - transmit byte, sample acknowledge, interrupt
// - receive byte then acknowledge sent
// - start and stop requests, stop interrupts
// - rate counter reloads, starts on buffer write
// - count down on second and fourth phases
// - operation end stops counter, clock holds
// - counter pauses until clock sampled high
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import i2cm_pkg::*;

  i2cm_state_t s;
  i2cm_state_t n;
  logic tick;
  logic done;
  logic reload;
  logic master;
  logic slave;
  logic wr_go;
  logic wr_buf_busy;
  logic gc_hit;
  logic own_hit;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] nsh;
  logic [7:0] wd;
  logic [7:0] rd;

  assign s_axi_awready = !s.aw_v && !s.bvalid;
  assign s_axi_wready = !s.w_v && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  // lines are only ever pulled low or released
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !((master && s.m_scl_low) || s.s_hold);
  assign sda_oe_n = !((master && s.m_sda_low) || s.s_ack);

  always_comb
  begin
    n = s;
    reload = 1'b0;
    gc_hit = 1'b0;
    own_hit = 1'b0;
    wr_buf_busy = 1'b0;
    rd = 8'h00;
    wd = s.w_d[7:0];
    tick = s.phase[0];
    done = s.brg_run && tick && (s.rate_counter == 8'h00);
    master = s.en && (s.mode == `I2CM_MODE_MASTER);
    slave = s.en && ((s.mode == `I2CM_MODE_S7) || (s.mode == `I2CM_MODE_S10));
    scl_rise = s.scl_s && !s.scl_d;
    scl_fall = !s.scl_s && s.scl_d;
    start_det = s.scl_s && s.scl_d && s.sda_d && !s.sda_s;
    stop_det = s.scl_s && s.scl_d && !s.sda_d && s.sda_s;
    nsh = {s.sshift[6:0], s.sda_s};
    wr_go = s.aw_v && s.w_v;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    // Q1..Q4 phases; counter steps on Q2 and Q4
    n.phase = s.phase + 2'h1;
    if (s.brg_run && tick && (s.rate_counter != 8'h00))
      n.rate_counter = s.rate_counter - 8'h01;
    if (done)
      n.brg_run = 1'b0;
    // register bus
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_v = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_v = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (wr_go)
    begin
      n.aw_v = 1'b0;
      n.w_v = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `I2CM_RESP_OKAY;
      case (s.aw_a)
        `I2CM_OFF_CTRL1:
        if (s.w_s[0])
        begin
          n.write_collision_flag = s.write_collision_flag && wd[`I2CM_C1_WRITE_COLLISION_FLAG];
          n.en = wd[`I2CM_C1_EN];
          n.crb = wd[`I2CM_C1_CRB];
          n.mode = wd[3:0];
        end
        `I2CM_OFF_CTRL2:
        if (s.w_s[0])
        begin
          n.gce = wd[`I2CM_C2_GCE];
          n.ackdt = wd[`I2CM_C2_ACKDT];
          // no queueing: request bits ignored while an operation runs
          if (s.mst == M_IDLE && !(s.start_request_bit || s.rsen || s.stop_request_bit || s.rcen || s.acken))
          begin
            n.acken = wd[`I2CM_C2_ACKEN];
            n.rcen = wd[`I2CM_C2_RCEN];
            n.stop_request_bit = wd[`I2CM_C2_PEN];
            n.rsen = wd[`I2CM_C2_RSEN];
            n.start_request_bit = wd[`I2CM_C2_SEN];
          end
        end
        `I2CM_OFF_STAT:
          n.bresp = `I2CM_RESP_OKAY;
        `I2CM_OFF_BUF:
        if (s.w_s[0])
        begin
          if (master && (s.mst != M_IDLE || s.start_request_bit || s.rsen || s.stop_request_bit || s.rcen || s.acken))
          begin
            wr_buf_busy = 1'b1;
            n.write_collision_flag = 1'b1;
          end
          else
          begin
            n.xbuf = wd;
            if (master)
            begin
              n.bf = 1'b1;
              n.mshift = wd;
              n.kind = K_TX;
              n.mbits = `I2CM_TX_BITS;
              n.m_scl_low = 1'b1;
              n.m_sda_low = !wd[7];
              n.mst = M_LOW;
              reload = 1'b1;
            end
          end
        end
        `I2CM_OFF_ADDR:
        if (s.w_s[0])
        begin
          n.addr = wd;
          n.ua = 1'b0;
        end
        `I2CM_OFF_EVT:
        if (s.w_s[0])
          n.irq = s.irq && wd[`I2CM_EVT_IRQ];
        default:
          n.bresp = `I2CM_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !s.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = `I2CM_RESP_OKAY;
      case (s_axi_araddr)
        `I2CM_OFF_CTRL1: rd = {s.write_collision_flag, 1'b0, s.en, s.crb, s.mode};
        `I2CM_OFF_CTRL2: rd = {s.gce, s.ack_received_status, s.ackdt, s.acken, s.rcen, s.stop_request_bit, s.rsen, s.start_request_bit};
        `I2CM_OFF_STAT: rd = {3'h0, s.stop_seen, s.start_seen, 1'b0, s.ua, s.bf};
        `I2CM_OFF_BUF:
        begin
          rd = s.xbuf;
          n.bf = 1'b0;
        end
        `I2CM_OFF_ADDR: rd = s.addr;
        `I2CM_OFF_EVT: rd = {7'h00, s.irq};
        default: n.rresp = `I2CM_RESP_SLVERR;
      endcase
      n.rdata = {24'h000000, rd};
    end
    // bus condition flags
    if (s.en && start_det)
    begin
      n.start_seen = 1'b1;
      n.stop_seen = 1'b0;
    end
    if (s.en && stop_det)
    begin
      n.stop_seen = 1'b1;
      n.start_seen = 1'b0;
    end
    // controller sequencer
    if (master)
    begin
      case (s.mst)
        M_IDLE:
        if (s.start_request_bit)
        begin
          if (s.scl_s && s.sda_s)
          begin
            reload = 1'b1;
            n.mst = M_ST1;
          end
          else
            n.start_request_bit = 1'b0;
        end
        else if (s.rsen)
        begin
          n.m_scl_low = 1'b1;
          n.m_sda_low = 1'b0;
          reload = 1'b1;
          n.mst = M_RS1;
        end
        else if (s.stop_request_bit)
        begin
          n.m_scl_low = 1'b1;
          n.m_sda_low = 1'b1;
          reload = 1'b1;
          n.mst = M_SP1;
        end
        else if (s.rcen || s.acken)
        begin
          n.kind = s.rcen ? K_RX : K_ACK;
          n.mbits = s.rcen ? `I2CM_RX_BITS : `I2CM_ACK_BITS;
          n.m_scl_low = 1'b1;
          n.m_sda_low = s.rcen ? 1'b0 : !s.ackdt;
          reload = 1'b1;
          n.mst = M_LOW;
        end
        M_ST1:
        if (done)
        begin
          if (s.scl_s && s.sda_s)
          begin
            n.m_sda_low = 1'b1;
            reload = 1'b1;
            n.mst = M_ST2;
          end
          else
          begin
            n.start_request_bit = 1'b0;
            n.mst = M_IDLE;
          end
        end
        M_ST2:
        if (done)
        begin
          n.start_request_bit = 1'b0;
          n.irq = 1'b1;
          n.mst = M_IDLE;
        end
        M_LOW:
        if (done)
        begin
          n.m_scl_low = 1'b0;
          n.mst = M_HIGH;
        end
        M_HIGH:
        if (!s.brg_run)
        begin
          if (s.scl_s)
            reload = 1'b1;
        end
        else if (done)
        begin
          n.m_scl_low = 1'b1;
          n.mbits = s.mbits - 4'h1;
          if (s.kind == K_TX && s.mbits == `I2CM_LAST_BIT)
            n.ack_received_status = s.sda_s;
          if (s.kind == K_TX)
            n.mshift = {s.mshift[6:0], 1'b0};
          if (s.kind == K_RX)
            n.mshift = {s.mshift[6:0], s.sda_s};
          if (s.kind == K_TX && s.mbits == 4'h2)
            n.bf = 1'b0;
          if (s.mbits == `I2CM_LAST_BIT)
          begin
            n.irq = 1'b1;
            n.mst = M_IDLE;
            n.acken = 1'b0;
            if (s.kind == K_TX)
              n.m_sda_low = 1'b0;
            if (s.kind == K_RX)
            begin
              n.xbuf = {s.mshift[6:0], s.sda_s};
              n.bf = 1'b1;
              n.rcen = 1'b0;
            end
          end
          else
          begin
            n.m_sda_low = (s.kind == K_TX) && (s.mbits != 4'h2) && !s.mshift[6];
            reload = 1'b1;
            n.mst = M_LOW;
          end
        end
        M_SP1:
        if (done)
        begin
          n.m_scl_low = 1'b0;
          n.mst = M_SP2;
        end
        M_SP2:
        if (!s.brg_run)
        begin
          if (s.scl_s)
            reload = 1'b1;
        end
        else if (done)
        begin
          n.m_sda_low = 1'b0;
          reload = 1'b1;
          n.mst = M_SP3;
        end
        M_SP3:
        if (done)
        begin
          n.stop_request_bit = 1'b0;
          n.irq = 1'b1;
          n.mst = M_IDLE;
        end
        M_RS1:
        if (done)
        begin
          if (s.sda_s)
          begin
            n.m_scl_low = 1'b0;
            n.mst = M_RS2;
          end
          else
          begin
            n.rsen = 1'b0;
            n.mst = M_IDLE;
          end
        end
        M_RS2:
        if (!s.brg_run)
        begin
          if (s.scl_s)
            reload = 1'b1;
        end
        else if (done)
        begin
          n.m_sda_low = 1'b1;
          reload = 1'b1;
          n.mst = M_RS3;
        end
        M_RS3:
        if (done)
        begin
          n.rsen = 1'b0;
          n.irq = 1'b1;
          n.mst = M_IDLE;
        end
        default: n.mst = M_IDLE;
      endcase
    end
    // target side
    if (slave)
    begin
      if (start_det)
      begin
        n.slv = S_ADDR;
        n.sbits = 4'h0;
        n.s_second = 1'b0;
        n.s_ack = 1'b0;
      end
      else if (stop_det)
      begin
        n.slv = S_IDLE;
        n.s_ack = 1'b0;
      end
      else if (s.slv != S_IDLE)
      begin
        if (scl_rise && s.sbits < `I2CM_ACK_SLOT)
        begin
          n.sshift = nsh;
          n.sbits = s.sbits + 4'h1;
        end
        if (scl_rise && s.sbits == `I2CM_ACK_SLOT)
          n.sbits = `I2CM_BIT9;
        if (scl_rise && s.sbits == `I2CM_BIT8)
        begin
          if (s.slv == S_ADDR)
          begin
            gc_hit = s.gce && (nsh == `I2CM_GC_ADDR);
            if (s.mode == `I2CM_MODE_S7)
              own_hit = nsh[7:1] == s.addr[7:1];
            else if (!s.s_second)
              own_hit = (nsh[7:3] == `I2CM_TEN_PREFIX) && (nsh[2:1] == s.addr[2:1]);
            else
              own_hit = !s.ua && (nsh == s.addr);
            n.s_match = gc_hit || own_hit;
            n.s_gc = gc_hit;
            if (gc_hit || own_hit)
            begin
              n.xbuf = nsh;
              n.bf = 1'b1;
            end
            if (own_hit && !gc_hit && s.mode == `I2CM_MODE_S10)
              n.ua = 1'b1;
          end
          else
          begin
            n.s_match = !s.bf;
            if (!s.bf)
            begin
              n.xbuf = nsh;
              n.bf = 1'b1;
            end
          end
        end
        if (scl_fall && s.sbits == `I2CM_ACK_SLOT && s.s_match)
          n.s_ack = 1'b1;
        if (scl_fall && s.sbits == `I2CM_BIT9)
        begin
          n.s_ack = 1'b0;
          n.sbits = 4'h0;
          if (s.s_match)
            n.irq = 1'b1;
          if (!s.s_match)
            n.slv = S_IDLE;
          else if (s.slv == S_DATA)
            n.crb = s.bf ? 1'b0 : s.crb;
          else if (s.mode == `I2CM_MODE_S10 && !s.s_gc && !s.s_second)
            n.s_second = 1'b1;
          else
            n.slv = S_DATA;
        end
      end
    end
    // clock hold waits for the line to be low already
    n.s_hold = slave && !s.crb && (s.s_hold || !s.scl_s);
    if (reload)
    begin
      n.rate_counter = s.addr;
      n.brg_run = 1'b1;
      // every count starts on the same phase, so each half period is whole
      n.phase = `I2CM_PHASE_START;
    end
    if (!n.en)
    begin
      n.start_seen = 1'b0;
      n.stop_seen = 1'b0;
      n.mst = M_IDLE;
      n.slv = S_IDLE;
      n.m_scl_low = 1'b0;
      n.m_sda_low = 1'b0;
      n.s_ack = 1'b0;
      n.brg_run = 1'b0;
      {n.start_request_bit, n.rsen, n.stop_request_bit, n.rcen, n.acken} = 5'h00;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.crb <= `I2CM_CRB_RST;
      // released lines read high, so no false edge after reset
      {s.scl_m, s.scl_s, s.scl_d, s.sda_m, s.sda_s, s.sda_d} <= `I2CM_LINES_IDLE;
    end
    else
      s <= n;
  end

  property p_hold_low;
    @(posedge clock) disable iff (!reset_n) $rose(s.s_hold) |-> !$past(s.scl_s);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock hold began on high line");

  property p_hold_keep;
    @(posedge clock) disable iff (!reset_n) s.s_hold && !s.crb && slave |=> s.s_hold;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("clock hold dropped early");

  property p_gc_enable;
    @(posedge clock) disable iff (!reset_n)
      slave && s.slv == S_ADDR && scl_rise && s.sbits == `I2CM_BIT8 && !s.gce
      && nsh == `I2CM_GC_ADDR && s.addr[7:1] != 7'h00 |=> !s.s_match;
  endproperty
  a_gc_enable: assert property (p_gc_enable) else $error("general call without enable");

  property p_gc_buffer;
    @(posedge clock) disable iff (!reset_n) gc_hit |=> s.bf && s.xbuf == `I2CM_GC_ADDR && s.s_match;
  endproperty
  a_gc_buffer: assert property (p_gc_buffer) else $error("general call not buffered");

  property p_gc_no_ua;
    @(posedge clock) disable iff (!reset_n) gc_hit && !s.ua |=> !s.ua;
  endproperty
  a_gc_no_ua: assert property (p_gc_no_ua) else $error("general call set update flag");

  property p_flags_off;
    @(posedge clock) disable iff (!reset_n) !s.en |=> !s.start_seen && !s.stop_seen;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("bus flags kept while disabled");

  property p_write_collision_flag;
    @(posedge clock) disable iff (!reset_n) wr_buf_busy |=> s.write_collision_flag && s.xbuf == $past(s.xbuf);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy buffer write not refused");

  property p_brg_step;
    @(posedge clock) disable iff (!reset_n)
      s.brg_run && tick && s.rate_counter != 8'h00 |=> s.rate_counter == $past(s.rate_counter) - 8'h01 ##1 s.rate_counter == $past(s.rate_counter);
  endproperty
  a_brg_step: assert property (p_brg_step) else $error("rate counter step wrong");

  property p_pause;
    @(posedge clock) disable iff (!reset_n)
      master && s.mst == M_HIGH && !s.brg_run && !s.scl_s |=> !s.brg_run;
  endproperty
  a_pause: assert property (p_pause) else $error("counter ran while clock held low");

  property p_op_end;
    @(posedge clock) disable iff (!reset_n)
      master && s.mst == M_HIGH && done && s.mbits == `I2CM_LAST_BIT
      |=> s.irq && !s.brg_run && s.mst == M_IDLE && !scl_oe_n;
  endproperty
  a_op_end: assert property (p_op_end) else $error("operation end not held");
endmodule : i2cm_top

/* test/i2cm_bus_model.sv */
/*
  Two-wire target model: acks its own address and later data bytes,
  keeps the last byte seen and can stretch each clock low phase.
  Assumes scl/sda are wired-and with pull-ups, resolved in the bench.
*/
`timescale 1ns/1ps
module i2cm_bus_model #(
  parameter logic [6:0] TARGET_ADDR = 7'h52
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] stretch,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] last_byte
);
  logic scl_q;
  logic sda_q;
  logic data_ph;
  logic [3:0] bits;
  logic [7:0] sh;
  logic [7:0] hold;
  always @(posedge clock)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (!reset_n)
    begin
      {bits, scl_low, sda_low, data_ph, hold} <= '0;
    end
    else
    begin
      if (hold != 8'h00)
        hold <= hold - 8'h01;
      else
        scl_low <= 1'h0;
      // start or stop restarts the frame
      if (scl && scl_q && sda != sda_q)
      begin
        bits <= 4'h0;
        data_ph <= 1'h0;
        sda_low <= 1'h0;
      end
      else if (scl && !scl_q && bits < 4'h8)
      begin
        sh <= {sh[6:0], sda};
        bits <= bits + 4'h1;
      end
      else if (!scl && scl_q)
      begin
        // slow target holds the low phase
        if (stretch != 8'h00)
        begin
          scl_low <= 1'h1;
          hold <= stretch;
        end
        if (bits == 4'h8)
        begin
          last_byte <= sh;
          sda_low <= data_ph || sh[7:1] == TARGET_ADDR;
          data_ph <= data_ph || sh[7:1] == TARGET_ADDR;
          bits <= 4'h9;
        end
        else if (bits == 4'h9)
        begin
          sda_low <= 1'h0;
          bits <= 4'h0;
        end
      end
    end
  end
endmodule : i2cm_bus_model

/* test/i2c_master_slave_port_tb.sv */
/*
  Bench for i2cm_top: register map, target clock hold, general call,
  controller transfers. Assumes i2cm_bus_model on the same two wires.
*/
`timescale 1ns/1ps
module i2c_master_slave_port_tb;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] rs;} i2cm_row_t;
  logic clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scl_oe_n, sda_oe_n, scl_o, sda_o, m_scl, m_sda, tb_scl_low;
  logic tb_sda_low, ack, last;
  logic [7:0] s_axi_awaddr, s_axi_araddr, stretch, got;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors, check_count, run, min_low, min_high;
  real tnext;
  i2cm_row_t rows [7] = '{'{1'h0, 8'h00, 32'h10, 2'h0}, '{1'h0, 8'h08, 32'h00, 2'h0},
    '{1'h0, 8'h14, 32'h00, 2'h0}, '{1'h0, 8'h18, 32'h00, 2'h2},
    '{1'h1, 8'h10, 32'h03, 2'h0}, '{1'h0, 8'h10, 32'h03, 2'h0}, '{1'h1, 8'h1C, 32'h00, 2'h2}};
  wire scl = (scl_oe_n | scl_o) & !m_scl & !tb_scl_low;
  wire sda = (sda_oe_n | sda_o) & !m_sda & !tb_sda_low;
  i2cm_top u_dut (.clock, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .scl_in(scl), .scl_out(scl_o), .scl_oe_n,
    .sda_in(sda), .sda_out(sda_o), .sda_oe_n);
  i2cm_bus_model u_peer (.clock, .reset_n, .scl, .sda, .stretch, .scl_low(m_scl),
    .sda_low(m_sda), .last_byte(got));
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // shortest low and high runs seen on the clock wire
  always @(posedge clock)
  begin
    if (scl !== last)
    begin
      if (last === 1'h0 && run < min_low) min_low = run;
      if (last === 1'h1 && run < min_high) min_high = run;
      run = 0;
    end
    run = run + 1;
    last = scl;
  end
  task automatic stop_test;
    $display("checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw | w)
    begin
      @(posedge clock);
      if (aw && s_axi_awready)
      begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clock); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clock); while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic wait_irq;
    v = 32'h0;
    for (int n = 0; n < 400 && v[0] !== 1'h1; n++) rd(8'h14);
    chk("interrupt", v[0], 32'h1);
  endtask : wait_irq
  task automatic half;
    if (tnext < $realtime) tnext = $realtime;
    tnext = tnext + 62.5;
    while ($realtime < tnext) @(posedge clock);
  endtask : half
  task automatic bit_out(input logic b, output logic s);
    tb_scl_low <= 1'h1;
    tb_sda_low <= !b;
    half;
    tb_scl_low <= 1'h0;
    while (scl !== 1'h1) @(posedge clock);
    half;
    s = sda;
  endtask : bit_out
  task automatic start;
    tnext = $realtime;
    tb_sda_low <= 1'h1;
    half;
  endtask : start
  task automatic stop;
    tb_scl_low <= 1'h1;
    tb_sda_low <= 1'h1;
    half;
    tb_scl_low <= 1'h0;
    while (scl !== 1'h1) @(posedge clock);
    half;
    tb_sda_low <= 1'h0;
    half;
  endtask : stop
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(b[i], s);
    bit_out(1'h1, ack);
    tb_scl_low <= 1'h1;
    half;
  endtask : send
  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    stop_test;
  end
  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tb_scl_low, tb_sda_low} = '0;
    {s_axi_awaddr, s_axi_araddr, stretch, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    repeat (2) @(posedge clock);
    foreach (rows[i])
    begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      chk("response", r, rows[i].rs);
      if (!rows[i].w && rows[i].rs == 2'h0) chk("register", v, rows[i].d);
    end
    // target mode, clock hold against an outside pull
    wr(8'h00, 32'h36);
    wr(8'h00, 32'h26);
    repeat (10) @(posedge clock);
    chk("clock enable", scl_oe_n, 32'h1);
    tb_scl_low <= 1'h1;
    repeat (10) @(posedge clock);
    tb_scl_low <= 1'h0;
    repeat (10) @(posedge clock);
    chk("held clock", scl, 32'h0);
    wr(8'h00, 32'h36);
    repeat (10) @(posedge clock);
    chk("released clock", scl, 32'h1);
    // general call in ten-bit target mode
    wr(8'h10, 32'hF0);
    wr(8'h00, 32'h37);
    wr(8'h04, 32'h80);
    start;
    send(8'h00);
    chk("call ack", ack, 32'h0);
    rd(8'h14);
    chk("call event", v, 32'h1);
    rd(8'h08);
    chk("call status", v & 32'h3, 32'h1);
    rd(8'h0C);
    chk("call buffer", v, 32'h0);
    wr(8'h14, 32'h0);
    send(8'h3C);
    chk("data ack", ack, 32'h0);
    rd(8'h0C);
    chk("data", v, 32'h3C);
    wr(8'h00, 32'h37);
    stop;
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0);
    start;
    send(8'h00);
    chk("ignored call", ack, 32'h1);
    stop;
    rd(8'h14);
    chk("no event", v, 32'h0);
    // controller transfers
    wr(8'h00, 32'h18);
    wr(8'h00, 32'h38);
    wr(8'h10, 32'h03);
    rd(8'h08);
    chk("idle flags", v & 32'h18, 32'h0);
    wr(8'h04, 32'h01);
    wait_irq;
    rd(8'h08);
    chk("start seen", v & 32'h18, 32'h08);
    wr(8'h14, 32'h0);
    min_low = 255;
    wr(8'h0C, 32'hA4);
    wr(8'h0C, 32'h11);
    rd(8'h00);
    chk("collision", v, 32'hB8);
    wait_irq;
    rd(8'h04);
    chk("ack status", v & 32'h40, 32'h0);
    chk("address byte", got, 32'hA4);
    chk("low time", min_low, 32'h8);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h38);
    stretch <= 8'h14;
    min_high = 255;
    wr(8'h0C, 32'h5B);
    wait_irq;
    chk("data byte", got, 32'h5B);
    chk("high time", min_high >= 8, 32'h1);
    stretch <= 8'h00;
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h08);
    wait_irq;
    rd(8'h0C);
    chk("received byte", v, 32'hFF);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h10);
    wait_irq;
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h04);
    wait_irq;
    rd(8'h08);
    chk("stop seen", v & 32'h18, 32'h10);
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    repeat (2) @(posedge clock);
    rd(8'h08);
    chk("reset flags", v & 32'h18, 32'h0);
    rd(8'h00);
    chk("reset control", v, 32'h10);
    wr(8'h00, 32'h18);
    rd(8'h08);
    chk("disabled flags", v & 32'h18, 32'h0);
    stop_test;
  end
endmodule : i2c_master_slave_port_tb
